// *** rtl/lsu_pkg.sv ***
package lsu_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int CUR_W = 16;
   localparam int DLY_W = 24;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [DLY_W-1:0] DLY_RST = 24'h000000;
   localparam logic SHED_RST = 1'b0;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MOT_STOP, MOT_START, MOT_RUN, MOT_OTHER
   } lsu_motor_t;

   typedef enum {
      LS_IDLE, LS_PICKUP, LS_SHED, LS_DROP
   } lsu_state_t;
endpackage

// *** rtl/lsu_load_shed_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsu_load_shed_unit
   import lsu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic shedEnable,
   input wire logic contactOpensOnShed,
   input wire lsu_pkg::lsu_motor_t motorState,
   input wire logic [lsu_pkg::CUR_W-1:0] loadCurrent,
   input wire logic [lsu_pkg::CUR_W-1:0] pickupLevel,
   input wire logic [lsu_pkg::CUR_W-1:0] dropoutLevel,
   input wire logic [lsu_pkg::DLY_W-1:0] pickupDelay,
   input wire logic [lsu_pkg::DLY_W-1:0] dropDelay,
   output logic shedActive,
   output logic contactClosed
);
   import lsu_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   lsu_state_t state_r;
   lsu_state_t state_nxt;
   logic [DLY_W-1:0] timer_r;
   logic [DLY_W-1:0] timer_nxt;
   logic shed_r;
   logic shed_nxt;
   logic contact_r;
   logic contact_nxt;

   // ----------------------------------------
   // Qualification
   // ----------------------------------------
   // Losing either gate drops a running shed on the next edge
   wire runState = (motorState == MOT_RUN);
   wire armed = shedEnable && runState;
   wire disarm = !armed;

   // ----------------------------------------
   // Threshold comparison
   // ----------------------------------------
   // Strict compares: equal to pickup is no overload, equal to dropout no relief
   wire abovePickup = loadCurrent > pickupLevel;
   wire belowDropout = loadCurrent < dropoutLevel;
   wire atOrBelowPickup = !abovePickup;
   wire atOrAboveDropout = !belowDropout;

   // ----------------------------------------
   // Timer decode
   // ----------------------------------------
   wire [DLY_W-1:0] timerStep = {{(DLY_W-1){1'b0}}, 1'b1};
   wire [DLY_W-1:0] timerInc = timer_r + timerStep;
   wire pickupDone = timer_r >= pickupDelay;
   wire dropZero = (dropDelay == DLY_RST);
   wire dropDone = timerInc >= dropDelay;

   // ----------------------------------------
   // State decode
   // ----------------------------------------
   wire inIdle = (state_r == LS_IDLE);
   wire inPickup = (state_r == LS_PICKUP);
   wire inShed = (state_r == LS_SHED);
   wire inDrop = (state_r == LS_DROP);

   // ----------------------------------------
   // Transition conditions
   // ----------------------------------------
   wire startPickup = inIdle && abovePickup;
   wire abortPickup = inPickup && atOrBelowPickup;
   wire enterShed = inPickup && abovePickup && pickupDone;
   wire keepPickup = inPickup && abovePickup && !pickupDone;
   wire releaseNow = inShed && belowDropout && dropZero;
   wire startDrop = inShed && belowDropout && !dropZero;
   wire resumeShed = inDrop && atOrAboveDropout;
   wire dropExpired = inDrop && belowDropout && dropDone;
   wire keepDrop = inDrop && belowDropout && !dropDone;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         LS_IDLE: begin
            if (startPickup) begin
               state_nxt = LS_PICKUP;
            end
         end
         LS_PICKUP: begin
            if (abortPickup) begin
               state_nxt = LS_IDLE;
            end else if (enterShed) begin
               state_nxt = LS_SHED;
            end
         end
         LS_SHED: begin
            if (releaseNow) begin
               state_nxt = LS_IDLE;
            end else if (startDrop) begin
               state_nxt = LS_DROP;
            end
         end
         LS_DROP: begin
            if (resumeShed) begin
               state_nxt = LS_SHED;
            end else if (dropExpired) begin
               state_nxt = LS_IDLE;
            end
         end
         default: begin
            state_nxt = LS_IDLE;
         end
      endcase
      if (disarm) begin
         state_nxt = LS_IDLE;
      end
   end

   // ----------------------------------------
   // Next timer value
   // ----------------------------------------
   // The timer only counts while a delay is pending; every exit clears it
   always_comb begin
      timer_nxt = DLY_RST;
      case (state_r)
         LS_IDLE: begin
            timer_nxt = DLY_RST;
         end
         LS_PICKUP: begin
            if (keepPickup) begin
               timer_nxt = timerInc;
            end else begin
               timer_nxt = DLY_RST;
            end
         end
         LS_SHED: begin
            timer_nxt = DLY_RST;
         end
         LS_DROP: begin
            if (keepDrop) begin
               timer_nxt = timerInc;
            end else begin
               timer_nxt = DLY_RST;
            end
         end
         default: begin
            timer_nxt = DLY_RST;
         end
      endcase
      if (disarm) begin
         timer_nxt = DLY_RST;
      end
   end

   // ----------------------------------------
   // Output selection
   // ----------------------------------------
   // Indication covers the drop wait as well, so shed holds until release
   assign shed_nxt = (state_nxt == LS_SHED) || (state_nxt == LS_DROP);
   assign contact_nxt = shed_nxt ^ contactOpensOnShed;

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= LS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Timer register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_r <= DLY_RST;
      end else begin
         timer_r <= timer_nxt;
      end
   end

   // ----------------------------------------
   // Indication register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shed_r <= SHED_RST;
      end else begin
         shed_r <= shed_nxt;
      end
   end

   // ----------------------------------------
   // Contact register
   // ----------------------------------------
   // Reset leaves the contact open whatever the mode; the first edge fixes it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         contact_r <= SHED_RST;
      end else begin
         contact_r <= contact_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign shedActive = shed_r;
   assign contactClosed = contact_r;

endmodule
`default_nettype wire

// *** dv/lsu_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsu_chk import lsu_pkg::*; (
   input wire logic clk, rst_b, shedEnable, shedActive,
   input wire logic contactOpensOnShed, contactClosed,
   input wire lsu_motor_t motorState,
   input wire logic [CUR_W-1:0] loadCurrent, dropoutLevel, pickupLevel,
   input wire logic [DLY_W-1:0] dropDelay
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_off_idle: assert property (!shedEnable |=> !shedActive)
      else $error("shed while off");
   chk_run_only: assert property (motorState != MOT_RUN |=> !shedActive)
      else $error("shed out of run");
   chk_shed_hold: assert property (shedActive && shedEnable && motorState == MOT_RUN
      && loadCurrent >= dropoutLevel |=> shedActive) else $error("early release");
   chk_contact_map: assert property (rst_b |=>
      contactClosed == (shedActive ^ $past(contactOpensOnShed))) else $error("contact wrong");
   chk_pick_cause: assert property ($rose(shedActive) |->
      $past(loadCurrent > pickupLevel)) else $error("shed without overload");
   chk_pick_clear: assert property (!shedActive && loadCurrent <= pickupLevel
      |=> !shedActive) else $error("shed at pickup");
   chk_zero_drop: assert property (shedActive && dropDelay == 0
      && loadCurrent < dropoutLevel |=> !shedActive) else $error("late zero release");
   cover property ($rose(shedActive));
   cover property ($fell(shedActive));
   cover property (shedActive ##1 !shedEnable);
endmodule
bind lsu_load_shed_unit lsu_chk chk(.clk(clk), .rst_b(rst_b), .shedEnable(shedEnable),
   .shedActive(shedActive), .contactOpensOnShed(contactOpensOnShed),
   .contactClosed(contactClosed), .motorState(motorState), .loadCurrent(loadCurrent),
   .dropoutLevel(dropoutLevel), .pickupLevel(pickupLevel), .dropDelay(dropDelay));
`default_nettype wire

// *** dv/lsu_plant.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsu_plant (
   input wire logic contactClosed,
   input wire logic contactOpensOnShed,
   output logic feedReduced
);
   assign feedReduced = contactClosed ^ contactOpensOnShed;
endmodule
`default_nettype wire

// *** dv/lsu_load_shed_unit_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsu_load_shed_unit_tb;
   import lsu_pkg::*;
   logic clk, rst_b, shedEnable, contactOpensOnShed, shedActive, contactClosed, feedReduced;
   lsu_motor_t motorState;
   logic [15:0] loadCurrent, pickupLevel, dropoutLevel;
   logic [23:0] pickupDelay, dropDelay;
   int failures = 0, checks = 0;
   lsu_load_shed_unit uut(.clk(clk), .rst_b(rst_b), .shedEnable(shedEnable),
      .contactOpensOnShed(contactOpensOnShed), .motorState(motorState),
      .loadCurrent(loadCurrent), .pickupLevel(pickupLevel), .dropoutLevel(dropoutLevel),
      .pickupDelay(pickupDelay), .dropDelay(dropDelay), .shedActive(shedActive),
      .contactClosed(contactClosed));
   lsu_plant plant(.contactClosed(contactClosed), .contactOpensOnShed(contactOpensOnShed),
      .feedReduced(feedReduced));
   initial begin clk = 0; forever #2.5 clk = ~clk; end
   task ck(input logic a, input logic e);
      checks++;
      if (a !== e) begin failures++; $display("CHECK FAILED %0t mismatch", $time); end
   endtask
   task finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task up(input logic [23:0] d);
      @(posedge clk); pickupDelay <= d; loadCurrent <= 16'h0065;
      repeat (d + 1) @(posedge clk);
      #1 ck(shedActive, 1'b0);
      @(posedge clk); #1 ck(shedActive, 1'b1);
   endtask
   task dn(input logic [23:0] d);
      @(posedge clk); dropDelay <= d; loadCurrent <= 16'h0032;
      repeat (6) @(posedge clk);
      #1 ck(shedActive, 1'b1);
      @(posedge clk); loadCurrent <= 16'h0031;
      repeat (d) @(posedge clk);
      #1 ck(shedActive, 1'b1);
      @(posedge clk); #1 ck(shedActive, 1'b0);
   endtask
   task t_pick;
      @(posedge clk); loadCurrent <= 16'h0065;
      @(posedge clk); loadCurrent <= 16'h0064;
      repeat (8) @(posedge clk);
      #1 ck(shedActive, 1'b0);
      up(3);
      repeat (2) @(posedge clk);
      #1 ck(feedReduced, 1'b1);
      $display("t_pick done");
   endtask
   task t_gate;
      up(0);
      @(posedge clk); motorState <= MOT_STOP;
      repeat (2) @(posedge clk);
      #1 ck(shedActive, 1'b0);
      @(posedge clk); motorState <= MOT_RUN; contactOpensOnShed <= 1'b1;
      repeat (5) @(posedge clk);
      #1 ck(feedReduced, 1'b1);
      ck(contactClosed, 1'b0);
      @(posedge clk); shedEnable <= 1'b0;
      repeat (3) @(posedge clk);
      #1 ck(feedReduced, 1'b0);
      ck(contactClosed, 1'b1);
      $display("t_gate done");
   endtask
   initial begin
      rst_b = 0; shedEnable = 1; contactOpensOnShed = 0; motorState = MOT_RUN;
      loadCurrent = 0; pickupLevel = 16'h0064; dropoutLevel = 16'h0032;
      pickupDelay = 3; dropDelay = 0;
      repeat (3) @(posedge clk); rst_b <= 1;
      t_pick; dn(2); up(0); dn(0); $display("t_drop done"); t_gate;
      finish_test;
   end
   initial begin #5000; failures++; finish_test; end
endmodule
`default_nettype wire
